// [dvc_map.svh]
// register offsets, field positions, reset values and counts of the
// port c video output block.
// assumes: included by bare name from the package and the testbench.
`ifndef DVC_MAP_SVH
`define DVC_MAP_SVH

// --------------------------------------------------------------------
// register offsets (byte addresses)
// --------------------------------------------------------------------
`define DVC_OFF_CTRL    8'h00
`define DVC_OFF_STATUS  8'h04
`define DVC_OFF_MASK    8'h08
`define DVC_OFF_STRAP   8'h0C
`define DVC_OFF_HIC     8'h74

// --------------------------------------------------------------------
// control field positions
// --------------------------------------------------------------------
`define DVC_CTRL_EN      0
`define DVC_CTRL_DUAL    1
`define DVC_CTRL_BORDER  2
`define DVC_CTRL_STALL   3
`define DVC_CTRL_RST     4'h0

// --------------------------------------------------------------------
// status and mask field positions
// --------------------------------------------------------------------
`define DVC_ST_HOTPLUG   0
`define DVC_ST_STALL     1
`define DVC_ST_FIELD     2
`define DVC_ST_RST       3'h0
`define DVC_MASK_RST     3'h0

// --------------------------------------------------------------------
// strap and host interface control fields
// --------------------------------------------------------------------
`define DVC_STRAP_DET    8
`define DVC_HIC_MUX      1

// --------------------------------------------------------------------
// timing counts
// --------------------------------------------------------------------
`define DVC_HALF_CYC     2
`define DVC_STRAP_WAIT   2'h3

`endif

// [dvc_pkg.sv]
// types shared by the port c video output block.
// assumes: compiled before the design modules.
`include "dvc_map.svh"

package dvc_pkg;

  typedef enum logic [0:0] {
    STRAP_WAIT,
    STRAP_DONE
  } dvc_strap_state_type;

  typedef enum logic [1:0] {
    PINS_IDLE,
    PINS_VIDEO,
    PINS_AGP
  } dvc_pin_mode_type;

endpackage

// [dvc_port_c.sv]
// port c digital video output with the shared agp pin mux and straps.
// assumes: pixels and timing come from the display pipe on core_clk_in;
// the pad ring resolves pin levels from the enables.
//
// Functional notes
// - one 12-bit word per forwarded clock edge, 24 bits per period
// - dual channel: upper 12 pixel bits leave on port c
// - dual channel: lower 12 pixel bits leave on port b
// - hsync and vsync travel with the port c pixel stream
// - active-low blank, selectable blank or border meaning
// - software picks field or stall use of the field/stall input
// - field use: overlay field follows encoder field when interleaved
// - stall use: pixel pipeline holds for one horizontal line
// - shared active-low interrupt pin is an interrupt source
// - 8-bit add-in identification strap is readable by software
// - detect strap 0 means a video device is present
// - detect strap shares parity pin and picks agp or video pins
// - internal pull-down makes an open detect strap read low
// - detect high sets mux select bit 1 at 74h to agp
// - video mode samples sideband address pins as ident strap
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module dvc_port_c
  import dvc_pkg::*;
#(
  parameter int HALF_CYC = `DVC_HALF_CYC
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  output logic             irq_out,
  // display pipe
  input  wire logic [23:0] pix_data_in,
  input  wire logic        tim_hsync_in,
  input  wire logic        tim_vsync_in,
  input  wire logic        tim_active_in,
  input  wire logic        tim_border_in,
  input  wire logic        ovl_interleave_in,
  output logic             pix_take_out,
  output logic             pipe_hold_out,
  output logic             ovl_field_out,
  // agp core drive when the pins are in agp use
  input  wire logic [31:0] agp_ad_drv_in,
  input  wire logic [31:0] agp_ad_oe_in,
  input  wire logic [3:0]  agp_cbe_drv_in,
  input  wire logic        agp_cbe_oe_in,
  input  wire logic [3:0]  agp_stb_drv_in,
  input  wire logic        agp_stb_oe_in,
  input  wire logic [4:0]  agp_ctl_drv_in,
  input  wire logic [4:0]  agp_ctl_oe_in,
  input  wire logic        agp_par_drv_in,
  input  wire logic        agp_par_oe_in,
  // serial management lines, open drain
  input  wire logic [5:0]  ser_drv_low_in,
  output logic      [5:0]  ser_level_out,
  // shared pins
  input  wire logic [31:0] shr_ad_in,
  output logic      [31:0] shr_ad_out,
  output logic      [31:0] shr_ad_oe_out,
  output logic      [3:0]  shr_cbe_out,
  output logic      [3:0]  shr_cbe_oe_out,
  output logic      [3:0]  shr_stb_out,
  output logic      [3:0]  shr_stb_oe_out,
  input  wire logic [4:0]  shr_ctl_in,
  output logic      [4:0]  shr_ctl_out,
  output logic      [4:0]  shr_ctl_oe_out,
  input  wire logic        shr_par_in,
  output logic             shr_par_out,
  output logic             shr_par_oe_out,
  input  wire logic [7:0]  shr_sba_in
);

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  // the detect strap resets low, as the pad pull-down would leave it
  logic [16:0] pin_sync;
  dvc_sync2 #(
    .WIDTH   (17),
    .RST_VAL (17'h00001)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .async_in    ({shr_ad_in[15], shr_ctl_in, shr_sba_in, shr_par_in,
                   shr_ad_in[31], shr_ad_in[30]}),
    .sync_out    (pin_sync)
  );

  wire       irq_pin_n = pin_sync[0];
  wire       fs_pin    = pin_sync[1];
  wire       det_pin   = pin_sync[2];
  wire [7:0] sba_pin   = pin_sync[10:3];
  assign ser_level_out = pin_sync[16:11];

  // ------------------------------------------------------------------
  // straps, caught after reset release
  // ------------------------------------------------------------------
  dvc_strap_state_type strap_state;
  logic [1:0] strap_cnt;
  logic       det_strap;
  logic [7:0] addin_ident_strap;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_state       <= STRAP_WAIT;
      strap_cnt         <= 2'h0;
      det_strap         <= 1'b0;
      addin_ident_strap <= 8'h00;
    end else begin
      unique case (strap_state)
        STRAP_WAIT: begin
          strap_cnt <= strap_cnt + 2'h1;
          if (strap_cnt == `DVC_STRAP_WAIT) begin
            strap_state <= STRAP_DONE;
            det_strap   <= det_pin;
            // ident only means something with video devices fitted
            addin_ident_strap <= det_pin ? 8'h00 : sba_pin;
          end
        end
        STRAP_DONE: begin
          strap_cnt <= strap_cnt;
        end
      endcase
    end
  end

  dvc_pin_mode_type pin_mode;
  assign pin_mode = (strap_state == STRAP_WAIT) ? PINS_IDLE :
                    (det_strap ? PINS_AGP : PINS_VIDEO);
  wire vid_mode = (pin_mode == PINS_VIDEO);
  wire agp_mode = (pin_mode == PINS_AGP);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [3:0] ctrl;
  logic [2:0] status;
  logic [2:0] mask;
  logic [2:0] events;

  wire en         = ctrl[`DVC_CTRL_EN] & vid_mode;
  wire dual       = ctrl[`DVC_CTRL_DUAL];
  wire border_sel = ctrl[`DVC_CTRL_BORDER];
  wire stall_mode = ctrl[`DVC_CTRL_STALL];

  wire wr_ctrl = reg_wr_in && (reg_addr_in == `DVC_OFF_CTRL);
  wire wr_mask = reg_wr_in && (reg_addr_in == `DVC_OFF_MASK);
  wire rd_stat = reg_rd_in && (reg_addr_in == `DVC_OFF_STATUS);

  // a read clears status, but an event in the same cycle survives it
  wire [2:0] next_status = (rd_stat ? 3'h0 : status) | events;

  logic [31:0] rd_mux;
  always_comb begin
    unique case (reg_addr_in)
      `DVC_OFF_CTRL:   rd_mux = {28'h0000000, ctrl};
      `DVC_OFF_STATUS: rd_mux = {29'h00000000, status};
      `DVC_OFF_MASK:   rd_mux = {29'h00000000, mask};
      `DVC_OFF_STRAP:  rd_mux = {23'h000000, det_strap,
                                 addin_ident_strap};
      `DVC_OFF_HIC:    rd_mux = {30'h00000000, agp_mode, 1'b0};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl          <= `DVC_CTRL_RST;
      mask          <= `DVC_MASK_RST;
      status        <= `DVC_ST_RST;
      reg_rdata_out <= 32'h00000000;
    end else begin
      if (wr_ctrl) ctrl <= reg_wdata_in[3:0];
      if (wr_mask) mask <= reg_wdata_in[2:0];
      status        <= next_status;
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h00000000;
    end
  end

  assign irq_out = |(status & mask);

  // ------------------------------------------------------------------
  // line and field events
  // ------------------------------------------------------------------
  logic hs_prev, vs_prev, fs_prev, irq_prev, hold;
  wire  hs_edge  = tim_hsync_in & ~hs_prev;
  wire  vs_edge  = tim_vsync_in & ~vs_prev;
  wire  fs_chg   = fs_pin ^ fs_prev;
  // stall is looked at only on a line start, inside horizontal blanking
  wire  stall_ev = vid_mode & stall_mode & hs_edge & fs_pin;
  wire  fld_ev   = vid_mode & ~stall_mode & fs_chg;
  wire  hp_ev    = vid_mode & irq_prev & ~irq_pin_n;

  always_comb begin
    events = 3'h0;
    events[`DVC_ST_HOTPLUG] = hp_ev;
    events[`DVC_ST_STALL]   = stall_ev;
    events[`DVC_ST_FIELD]   = fld_ev;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hs_prev       <= 1'b0;
      vs_prev       <= 1'b0;
      fs_prev       <= 1'b0;
      irq_prev      <= 1'b1;
      hold          <= 1'b0;
      ovl_field_out <= 1'b0;
    end else begin
      hs_prev  <= tim_hsync_in;
      vs_prev  <= tim_vsync_in;
      fs_prev  <= fs_pin;
      irq_prev <= irq_pin_n;
      if (hs_edge) hold <= stall_ev;
      if (!stall_mode && ovl_interleave_in) begin
        ovl_field_out <= fs_pin;
      end else if (vs_edge) begin
        ovl_field_out <= ~ovl_field_out;
      end
    end
  end

  assign pipe_hold_out = hold;

  // ------------------------------------------------------------------
  // double-edge pixel output
  // ------------------------------------------------------------------
  // data move one core cycle after each clock edge and the next edge comes
  // HALF_CYC-1 cycles later, so every word is settled on both sides of its edge
  logic [7:0]  div_cnt;
  logic        fwd_clk;
  logic [23:0] pix_q;
  logic [11:0] port_c_pixel_bus, port_b_pixel_bus;
  logic        hs_q, vs_q, blank_n_q;

  wire tick_load = en && (div_cnt == 8'h00);
  wire tick_edge = en && (div_cnt == 8'(HALF_CYC - 1));
  wire take      = tick_load && (dual || !fwd_clk) && !hold;
  wire blank_lvl = border_sel ? (tim_active_in | tim_border_in)
                              : tim_active_in;
  assign pix_take_out = take;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_cnt <= 8'h00;
      fwd_clk <= 1'b0;
    end else if (!en) begin
      div_cnt <= 8'h00;
      fwd_clk <= 1'b0;
    end else if (tick_edge) begin
      div_cnt <= 8'h00;
      fwd_clk <= ~fwd_clk;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pix_q            <= 24'h000000;
      port_c_pixel_bus <= 12'h000;
      port_b_pixel_bus <= 12'h000;
      hs_q             <= 1'b0;
      vs_q             <= 1'b0;
      blank_n_q        <= 1'b0;
    end else if (!en) begin
      port_c_pixel_bus <= 12'h000;
      port_b_pixel_bus <= 12'h000;
      blank_n_q        <= 1'b0;
    end else if (take) begin
      pix_q            <= pix_data_in;
      port_c_pixel_bus <= pix_data_in[23:12];
      port_b_pixel_bus <= dual ? pix_data_in[11:0]
                               : 12'h000;
      hs_q             <= tim_hsync_in;
      vs_q             <= tim_vsync_in;
      blank_n_q        <= blank_lvl;
    end else if (tick_load && !dual && fwd_clk) begin
      port_c_pixel_bus <= pix_q[11:0];
    end
  end

  // ------------------------------------------------------------------
  // shared pin map
  // ------------------------------------------------------------------
  logic [31:0] vid_ad, vid_oe;
  always_comb begin
    vid_ad = 32'h00000000;
    vid_oe = 32'h00000000;
    {vid_ad[11], vid_ad[12], vid_ad[9], vid_ad[10], vid_ad[8], vid_ad[6],
     vid_ad[7], vid_ad[4], vid_ad[5], vid_ad[2], vid_ad[3]}
      = {port_b_pixel_bus[11:8], port_b_pixel_bus[6:0]};
    {vid_ad[28], vid_ad[29], vid_ad[26], vid_ad[27], vid_ad[24],
     vid_ad[25]} = port_c_pixel_bus[11:6];
    vid_ad[23:19] = port_c_pixel_bus[4:0];
    vid_ad[17]    = hs_q;
    vid_ad[16]    = vs_q;
    vid_ad[18]    = blank_n_q;
    vid_ad[0]     = hs_q;
    vid_ad[1]     = vs_q;
    vid_oe[29:16] = 14'h3FFF;
    vid_oe[12:0]  = 13'h1FFF;
    vid_oe[15]    = ser_drv_low_in[5];
  end

  assign shr_ad_out     = agp_mode ? agp_ad_drv_in : vid_ad;
  assign shr_ad_oe_out  = agp_mode ? agp_ad_oe_in
                        : (vid_mode ? vid_oe : 32'h00000000);
  assign shr_cbe_out    = agp_mode ? agp_cbe_drv_in
                        : {port_c_pixel_bus[5], 1'b0, blank_n_q,
                           port_b_pixel_bus[7]};
  assign shr_cbe_oe_out = agp_mode ? {4{agp_cbe_oe_in}}
                        : (vid_mode ? 4'hB : 4'h0);
  assign shr_stb_out    = agp_mode ? agp_stb_drv_in
                        : {~fwd_clk, ~fwd_clk, fwd_clk, fwd_clk};
  assign shr_stb_oe_out = {4{agp_mode ? agp_stb_oe_in : vid_mode}};
  assign shr_ctl_out    = agp_mode ? agp_ctl_drv_in : 5'h00;
  assign shr_ctl_oe_out = agp_mode ? agp_ctl_oe_in
                        : (vid_mode ? ser_drv_low_in[4:0] : 5'h00);
  assign shr_par_out    = agp_mode & agp_par_drv_in;
  assign shr_par_oe_out = agp_mode & agp_par_oe_in;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_upper_word;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      take |=> port_c_pixel_bus == $past(pix_data_in[23:12]);
  endproperty
  a_upper_word: assert property (p_upper_word)
    else $error("port c upper word wrong");

  property p_lower_half;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      tick_load && !dual && fwd_clk |=>
        port_c_pixel_bus == $past(pix_q[11:0]);
  endproperty
  a_lower_half: assert property (p_lower_half)
    else $error("second half word wrong");

  property p_port_b_lower;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      take && dual |=> port_b_pixel_bus == $past(pix_data_in[11:0]);
  endproperty
  a_port_b_lower: assert property (p_port_b_lower)
    else $error("port b lower word wrong");

  property p_sync_follow;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      take |=> hs_q == $past(tim_hsync_in) && vs_q == $past(tim_vsync_in);
  endproperty
  a_sync_follow: assert property (p_sync_follow)
    else $error("sync not with pixel");

  property p_blank_border;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      take && border_sel |=>
        blank_n_q == $past(tim_active_in | tim_border_in);
  endproperty
  a_blank_border: assert property (p_blank_border)
    else $error("border blank wrong");

  property p_hold_line;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      stall_ev |=> hold && !take;
  endproperty
  a_hold_line: assert property (p_hold_line)
    else $error("stall did not hold pipe");

  property p_field_align;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      !stall_mode && ovl_interleave_in && fs_chg |=>
        ovl_field_out == $past(fs_pin);
  endproperty
  a_field_align: assert property (p_field_align)
    else $error("overlay field not aligned");

  property p_hotplug_irq;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      hp_ev && mask[`DVC_ST_HOTPLUG] |=> status[`DVC_ST_HOTPLUG] && irq_out;
  endproperty
  a_hotplug_irq: assert property (p_hotplug_irq)
    else $error("hot plug not signalled");

  property p_agp_pins;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      agp_mode |-> shr_ad_oe_out == agp_ad_oe_in && !pix_take_out;
  endproperty
  a_agp_pins: assert property (p_agp_pins)
    else $error("agp mode pins not handed over");

endmodule

// [dvc_sink.sv]
// behavioural display transmitter on the shared pins in video use.
// assumes: video pin map of dvc_port_c; it resolves the pad levels.
`timescale 1ns/1ps

module dvc_sink (
  input  wire logic        core_clk_in,
  input  wire logic [31:0] pin_ad_in,
  input  wire logic [31:0] pin_ad_oe_in,
  input  wire logic [3:0]  pin_cbe_in,
  input  wire logic [3:0]  pin_stb_in,
  input  wire logic [4:0]  pin_ctl_in,
  input  wire logic [4:0]  pin_ctl_oe_in,
  input  wire logic        fs_req_in,
  input  wire logic        irq_req_in,
  input  wire logic        hblank_in,
  output logic      [31:0] ad_level_out,
  output logic      [4:0]  ctl_level_out
);
  logic [28:0] rec [$];
  logic        fs_pin = 1'b0;
  wire  [31:0] a = pin_ad_in;
  wire  [11:0] c_word = {a[28], a[29], a[26], a[27], a[24], a[25],
                         pin_cbe_in[3], a[23:19]};
  wire  [11:0] b_word = {a[11], a[12], a[9], a[10], pin_cbe_in[0], a[8],
                         a[6], a[7], a[4], a[5], a[2], a[3]};
  // ddc data is pulled up, unused field pins are pulled down
  wire  [31:0] ext = {fs_pin, ~irq_req_in, 14'h0000, 1'b1, 15'h0000};

  assign ad_level_out  = (pin_ad_oe_in & a) | (~pin_ad_oe_in & ext);
  // open drain serial lines with board pull-ups
  assign ctl_level_out = pin_ctl_in | ~pin_ctl_oe_in;

  // the panel only moves stall while its own line timing is blanked; the
  // pin blank freezes during a stall, so it cannot be used for this
  always @(posedge core_clk_in) begin
    if (hblank_in === 1'b1) begin
      fs_pin <= fs_req_in;
    end
  end

  // one record per forwarded clock edge: clocks, syncs, blank, both lanes
  always @(pin_stb_in[1]) begin
    rec.push_back({pin_stb_in[1], pin_stb_in[3], a[17], a[16], a[18],
                   b_word, c_word});
  end
endmodule

// [dvc_sync2.sv]
// two-stage synchroniser for a group of pin levels.
// assumes: inputs come from outside the core clock domain.
`timescale 1ns/1ps

module dvc_sync2 #(
  parameter int         WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // the first stage feeds only the second stage
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// [test_dvc_port_c.sv]
// self-checking bench of the port c video block and its shared pins.
// assumes: dvc_sink models the display side; straps are driven here.
`timescale 1ns/1ps
`include "dvc_map.svh"
`define CHK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end

module test_dvc_port_c;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] v;} dvc_row_type;
  logic        core_clk_in;
  logic        rst_b_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic        ovl_interleave_in = 1'b0;
  logic [31:0] agp_pat = 32'h0;
  logic [5:0]  ser_drv_low_in = 6'h00;
  logic        shr_par_in = 1'b0;
  logic [7:0]  shr_sba_in = 8'h35; // bit 7 low, on-board device
  logic        fs_req = 1'b0;
  logic        irq_req = 1'b0;
  logic [11:0] cyc = 12'h000;
  logic [11:0] n = 12'h000;
  logic [27:0] takes [$];
  logic [31:0] d, agp_ad_drv_in, agp_ad_oe_in, shr_ad_out, shr_ad_oe_out;
  logic [31:0] shr_ad_in, reg_rdata_out;
  logic [23:0] pix_data_in;
  logic [28:0] r;
  logic [27:0] t;
  logic [4:0]  agp_ctl_drv_in, agp_ctl_oe_in, shr_ctl_in, shr_ctl_out;
  logic [4:0]  shr_ctl_oe_out;
  logic [3:0]  agp_cbe_drv_in, agp_stb_drv_in, shr_cbe_out, shr_cbe_oe_out;
  logic [3:0]  shr_stb_out, shr_stb_oe_out;
  logic [5:0]  ser_level_out;
  logic        agp_cbe_oe_in, agp_stb_oe_in, agp_par_drv_in, agp_par_oe_in;
  logic        tim_hsync_in, tim_vsync_in, tim_active_in, tim_border_in;
  logic        irq_out, pix_take_out, pipe_hold_out, ovl_field_out;
  logic        shr_par_out, shr_par_oe_out, dl;
  logic [31:0] segs [4] = '{32'h1, 32'h7, 32'h3, 32'h5};
  dvc_row_type rows [12] = '{
    '{1'b0, 8'h00, 32'h0}, '{1'b0, 8'h04, 32'h0}, '{1'b0, 8'h08, 32'h0},
    '{1'b0, 8'h74, 32'h0}, '{1'b0, 8'h0C, 32'h35}, '{1'b0, 8'h10, 32'h0},
    '{1'b1, 8'h08, 32'h6}, '{1'b0, 8'h08, 32'h6}, '{1'b1, 8'h0C, 32'h1FF},
    '{1'b0, 8'h0C, 32'h35}, '{1'b1, 8'h00, 32'hB}, '{1'b0, 8'h00, 32'hB}};
  int          n_mismatch = 0;
  int          checked = 0;
  int          cycles = 0;
  int          k, m, w, tk, v;

  dvc_port_c #(.HALF_CYC(2)) i_dvc_port_c (.*);

  dvc_sink i_dvc_sink (
    .core_clk_in   (core_clk_in),
    .pin_ad_in     (shr_ad_out),
    .pin_ad_oe_in  (shr_ad_oe_out),
    .pin_cbe_in    (shr_cbe_out),
    .pin_stb_in    (shr_stb_out),
    .pin_ctl_in    (shr_ctl_out),
    .pin_ctl_oe_in (shr_ctl_oe_out),
    .fs_req_in     (fs_req),
    .irq_req_in    (irq_req),
    .hblank_in     (~tim_active_in),
    .ad_level_out  (shr_ad_in),
    .ctl_level_out (shr_ctl_in)
  );

  // --------------------------------------------------------------------
  // stimulus: one 64-cycle line, sync 0..3, border from 8, active from 16
  // --------------------------------------------------------------------
  assign tim_hsync_in   = cyc[5:0] < 6'h04;
  assign tim_vsync_in   = cyc[8:6] == 3'h0;
  assign tim_border_in  = cyc[5:0] >= 6'h08;
  assign tim_active_in  = cyc[5:0] >= 6'h10;
  assign pix_data_in    = {n ^ 12'hA5A, n};
  assign agp_ad_drv_in  = agp_pat;
  assign agp_ad_oe_in   = ~agp_pat;
  assign agp_cbe_drv_in = agp_pat[3:0];
  assign agp_cbe_oe_in  = agp_pat[4];
  assign agp_stb_drv_in = agp_pat[8:5];
  assign agp_stb_oe_in  = agp_pat[9];
  assign agp_ctl_drv_in = agp_pat[14:10];
  assign agp_ctl_oe_in  = agp_pat[19:15];
  assign agp_par_drv_in = agp_pat[20];
  assign agp_par_oe_in  = agp_pat[21];

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // taken pixels are logged with the timing levels that went with them
  always @(posedge core_clk_in) begin
    cyc <= cyc + 12'h001;
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      end_sim();
    end
    if (pix_take_out === 1'b1) begin
      takes.push_back({tim_hsync_in, tim_vsync_in, tim_active_in,
                       tim_border_in, pix_data_in});
      n <= n + 12'h001;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] val);
    @(posedge core_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= val;
    reg_wr_in    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in   <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge core_clk_in);
    #1;
  endtask

  task automatic end_sim;
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    tick(8);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].v);
      end else begin
        rd(rows[i].a);
        `CHK(d, rows[i].v)
      end
    end
    // ------------------------------------------------------------------
    // streams: single/dual lanes, blank/border meaning
    // ------------------------------------------------------------------
    foreach (segs[s]) begin
      wr(`DVC_OFF_CTRL, 32'h0);
      tick(8);
      takes.delete();
      i_dvc_sink.rec.delete();
      wr(`DVC_OFF_CTRL, segs[s]);
      tick(90);
      m = i_dvc_sink.rec.size();
      dl = segs[s][1];
      `CHK(m > 30, 1'b1)
      for (k = 0; k < m; k++) begin
        r = i_dvc_sink.rec[k];
        t = takes[dl ? k : k / 2];
        `CHK(r[28:27], {~k[0], k[0]})
        `CHK(r[11:0], (dl | ~k[0]) ? t[23:12] : t[11:0])
        if (dl) `CHK(r[23:12], t[11:0])
        `CHK(r[26:25], t[27:26])
        `CHK(r[24], t[25] | (segs[s][2] & t[24]))
      end
    end
    // field use follows the encoder while interleaved
    wr(`DVC_OFF_CTRL, 32'h1);
    ovl_interleave_in <= 1'b1;
    for (v = 1; v >= 0; v--) begin
      @(posedge core_clk_in);
      fs_req <= v[0];
      for (w = 0; w < 200 && ovl_field_out !== v[0]; w++) tick(1);
      `CHK(ovl_field_out, v[0])
    end
    // stall use: exactly one line held, no pixel taken meanwhile
    wr(`DVC_OFF_CTRL, 32'h9);
    rd(`DVC_OFF_STATUS);
    @(posedge core_clk_in);
    fs_req <= 1'b1;
    for (w = 0; w < 300 && pipe_hold_out !== 1'b1; w++) tick(1);
    @(posedge core_clk_in);
    fs_req <= 1'b0;
    tk = takes.size();
    for (w = 1; w < 200 && pipe_hold_out === 1'b1; w++) tick(1);
    `CHK(w, 64)
    `CHK(takes.size() - tk, 0)
    rd(`DVC_OFF_STATUS);
    `CHK(d[1], 1'b1)
    // hot-plug: masked, then unmasked, then cleared by the read
    wr(`DVC_OFF_MASK, 32'h0);
    rd(`DVC_OFF_STATUS);
    @(posedge core_clk_in);
    irq_req <= 1'b1;
    tick(8);
    @(posedge core_clk_in);
    irq_req <= 1'b0;
    tick(4);
    `CHK(irq_out, 1'b0)
    wr(`DVC_OFF_MASK, 32'h1);
    tick(1);
    `CHK(irq_out, 1'b1)
    rd(`DVC_OFF_STATUS);
    `CHK({d[0], irq_out}, 2'b10)
    // serial lines on their fixed pins
    @(posedge core_clk_in);
    ser_drv_low_in <= 6'h21;
    tick(4);
    `CHK(ser_level_out, 6'h1E)
    `CHK(shr_ad_oe_out, 32'h3FFF9FFF)
    `CHK({shr_cbe_oe_out, shr_ctl_oe_out}, 9'h161)
    // second reset with the board pulling the detect strap high
    @(posedge core_clk_in);
    shr_par_in <= 1'b1;
    rst_b_in   <= 1'b0;
    tick(3);
    `CHK(shr_ad_oe_out, 32'h0)
    @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    tick(10);
    rd(`DVC_OFF_HIC);
    `CHK(d, 32'h2)
    rd(`DVC_OFF_STRAP);
    `CHK(d, 32'h100)
    @(posedge core_clk_in);
    agp_pat <= 32'h5A3C96E1;
    tick(1);
    `CHK({shr_ad_out, shr_ad_oe_out}, 64'h5A3C96E1A5C3691E)
    end_sim();
  end
endmodule
